// ==== hw/sac_pkg.sv ====
package sac_pkg;

    // Register byte addresses (one aligned word each)
    localparam logic [7:0] SAC_OFF_CTRL_A   = 8'h00;
    localparam logic [7:0] SAC_OFF_CTRL_B   = 8'h04;
    localparam logic [7:0] SAC_OFF_INSEL    = 8'h08;
    localparam logic [7:0] SAC_OFF_RES_LOW  = 8'h0C;
    localparam logic [7:0] SAC_OFF_RES_HIGH = 8'h10;

    // Control A field positions
    localparam int SAC_A_PRESC_LSB = 0;
    localparam int SAC_A_IRQ_EN    = 3;
    localparam int SAC_A_DONE      = 4;
    localparam int SAC_A_AUTO      = 5;
    localparam int SAC_A_START     = 6;
    localparam int SAC_A_ENABLE    = 7;
    // Input select field positions
    localparam int SAC_I_CHAN_LSB  = 0;
    localparam int SAC_I_LEFT      = 5;
    localparam int SAC_I_REF_LSB   = 6;

    // Reset values
    localparam logic [7:0] SAC_RST_CTRL_A = 8'h00;
    localparam logic [7:0] SAC_RST_CTRL_B = 8'h00;
    localparam logic [7:0] SAC_RST_INSEL  = 8'h00;

    // Conversion lengths in converter clock cycles
    localparam int SAC_CYC_NORMAL = 13;
    localparam int SAC_CYC_FIRST  = 25;
    localparam int SAC_RES_BITS   = 10;

    // Trigger source codes
    localparam logic [2:0] SAC_TRIG_SELF = 3'h0;

    // Reference choices
    localparam logic [1:0] SAC_REF_PIN    = 2'h0;
    localparam logic [1:0] SAC_REF_SUPPLY = 2'h1;
    localparam logic [1:0] SAC_REF_INT256 = 2'h3;

    typedef enum logic [1:0] {
        SAC_SRC_PIN,
        SAC_SRC_GND,
        SAC_SRC_BANDGAP,
        SAC_SRC_DIFF
    } sac_src_t;

    // Analog front-end steering, travels as one bundle
    typedef struct packed {
        logic       active;
        logic [1:0] reference;
        logic       ref_to_pin;
        sac_src_t   source;
        logic [2:0] pos_chan;
        logic [2:0] neg_chan;
        logic [1:0] gain;
        logic       gain_bypass;
    } sac_afe_t;

endpackage : sac_pkg

// ==== hw/sac_top.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Ten-bit code by successive approximation
// - Reference from pin, supply or internal
// - Decode channel into single or gained pair
// - Ground and bandgap selectable single inputs
// - Selections apply only while converter enabled
// - Right-aligned default, left-aligned on request
// - Low byte read locks both bytes
// - Locked completion discards new result
// - High byte read releases the lock
// - Done event raised every conversion
// - Start bit begins conversion, self-clears
// - Channel change waits for running conversion
// - Auto trigger enable with selectable source
// - Trigger edge resets prescaler, starts conversion
// - Trigger still high needs fresh edge
// - Edges during conversion are ignored
// - Source flags set regardless of masking
// - Own done flag retriggers free running
// - Start bit works under auto trigger
// - Start bit reads one while converting
// - Thirteen cycles, twenty-five after enable
// - Prescaler runs only while enabled
// - Result and done flag land together
module sac_top
    import sac_pkg::*;
#(
    parameter int RES_BITS = SAC_RES_BITS
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  hsel,
    input  wire logic [7:0]            haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [7:1]            trigger_sources,
    input  wire logic                  comparator_high,
    output logic      [RES_BITS-1:0]   dac_code,
    output logic                       sample_hold,
    output sac_pkg::sac_afe_t          afe,
    output logic                       conversion_irq
);
    import sac_pkg::*;

    initial begin
        if (RES_BITS != 10) begin
            $error("sac_top: result layout serves only 10 bits");
        end
    end

    // Register state
    logic [7:0]          ctrl_a;
    logic [2:0]          trigger_source_select;
    logic [7:0]          input_select_register;
    logic [RES_BITS-1:0] result;
    logic                result_locked;
    logic                first_done;
    sac_afe_t            afe_lock;

    // AHB address phase capture
    logic       dp_valid;
    logic       dp_write;
    logic [7:0] dp_addr;

    wire addr_ok  = hsel && hready && htrans[1];
    wire wr_phase = dp_valid && dp_write;
    wire rd_phase = dp_valid && !dp_write;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else if (hready) begin
            dp_valid <= addr_ok;
            dp_write <= hwrite;
            dp_addr  <= haddr;
        end
    end

    wire wr_a    = wr_phase && dp_addr == SAC_OFF_CTRL_A;
    wire wr_b    = wr_phase && dp_addr == SAC_OFF_CTRL_B;
    wire wr_isel = wr_phase && dp_addr == SAC_OFF_INSEL;
    wire rd_low  = rd_phase && dp_addr == SAC_OFF_RES_LOW;
    wire rd_high = rd_phase && dp_addr == SAC_OFF_RES_HIGH;

    wire       converter_enable     = ctrl_a[SAC_A_ENABLE];
    wire       auto_trigger_enable  = ctrl_a[SAC_A_AUTO];
    wire       conversion_irq_enable = ctrl_a[SAC_A_IRQ_EN];
    wire       conversion_done_flag = ctrl_a[SAC_A_DONE];
    wire [2:0] presc_sel            = ctrl_a[SAC_A_PRESC_LSB +: 3];
    wire       result_left_adjust   = input_select_register[SAC_I_LEFT];

    // Result byte views, left or right aligned
    wire [15:0] res_word = result_left_adjust ? {result, 6'h00}
                                              : {6'h00, result};
    wire [7:0]  result_high_byte = res_word[15:8];
    wire [7:0]  result_low_byte  = res_word[7:0];

    // Converter clock: one-cycle enable from a power-of-two divider
    logic [7:0] presc_cnt;
    logic       busy;
    logic       trig_restart;
    wire  [7:0] presc_mask = (8'h02 << presc_sel) - 8'h01;
    wire        adc_tick   = converter_enable && ((presc_cnt & presc_mask) == presc_mask);

    always_ff @(posedge clk) begin
        if (!rst_n || !converter_enable || trig_restart) begin
            presc_cnt <= 8'h00;
        end else begin
            presc_cnt <= presc_cnt + 8'h01;
        end
    end

    // Trigger source choice; code zero is the block's own done flag
    wire [7:0] trig_vec   = {trigger_sources, conversion_done_flag};
    wire       trig_level = trig_vec[trigger_source_select];
    logic      trig_prev;
    wire       trig_rise  = trig_level && !trig_prev;
    // Free running restarts on every completion, flag cleared or not
    logic      done_pulse;
    wire       self_restart = auto_trigger_enable
                           && trigger_source_select == SAC_TRIG_SELF
                           && done_pulse;
    wire       auto_start = converter_enable && auto_trigger_enable
                           && ((trig_rise && !busy) || self_restart);
    wire       sw_start   = wr_a && hwdata[SAC_A_START] && hwdata[SAC_A_ENABLE];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_level;
        end
    end

    // Sequencer
    typedef enum logic [1:0] {SAC_IDLE, SAC_WAIT, SAC_SETTLE, SAC_BITS} sac_state_t;
    sac_state_t          state;
    logic [4:0]          cyc;
    logic [4:0]          settle_len;
    logic [3:0]          bit_idx;
    logic [RES_BITS-1:0] sar;
    logic                pending;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending      <= 1'b0;
            trig_restart <= 1'b0;
        end else begin
            trig_restart <= auto_start && !sw_start;
            pending      <= converter_enable && (pending || sw_start || auto_start)
                            && !(state == SAC_IDLE && adc_tick && pending);
        end
    end

    wire [4:0] conv_len = first_done ? 5'(SAC_CYC_NORMAL) : 5'(SAC_CYC_FIRST);

    // Sequencer steps on converter clock ticks only
    always_ff @(posedge clk) begin
        if (!rst_n || !converter_enable) begin
            state       <= SAC_IDLE;
            cyc         <= 5'd0;
            settle_len  <= 5'd0;
            bit_idx     <= 4'd0;
            sar         <= '0;
            done_pulse  <= 1'b0;
            busy        <= 1'b0;
            sample_hold <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            busy       <= pending || state != SAC_IDLE;
            if (adc_tick) begin
                case (state)
                    SAC_IDLE: begin
                        if (pending) begin
                            state       <= SAC_SETTLE;
                            cyc         <= 5'd1;
                            settle_len  <= conv_len - 5'(RES_BITS) - 5'd1;
                            sample_hold <= 1'b1;
                        end
                    end
                    SAC_SETTLE: begin
                        if (cyc >= settle_len) begin
                            state       <= SAC_BITS;
                            sample_hold <= 1'b0;
                            bit_idx     <= 4'(RES_BITS - 1);
                            sar         <= {1'b1, {(RES_BITS-1){1'b0}}};
                        end
                        cyc <= cyc + 5'd1;
                    end
                    SAC_BITS: begin
                        // Keep the trial bit when the input is above the DAC level
                        sar[bit_idx] <= comparator_high;
                        if (bit_idx == 4'd0) begin
                            state      <= SAC_WAIT;
                        end else begin
                            sar[bit_idx - 4'd1] <= 1'b1;
                            bit_idx <= bit_idx - 4'd1;
                        end
                    end
                    SAC_WAIT: begin
                        state      <= SAC_IDLE;
                        done_pulse <= 1'b1;
                    end
                    default: begin
                        state <= SAC_IDLE;
                    end
                endcase
            end
        end
    end

    // Trial code toward the DAC
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dac_code <= '0;
        end else begin
            dac_code <= sar;
        end
    end

    // Control A: done flag set wins over write-one clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_a <= SAC_RST_CTRL_A;
        end else begin
            if (wr_a) begin
                ctrl_a[SAC_A_ENABLE]         <= hwdata[SAC_A_ENABLE];
                ctrl_a[SAC_A_AUTO]           <= hwdata[SAC_A_AUTO];
                ctrl_a[SAC_A_IRQ_EN]         <= hwdata[SAC_A_IRQ_EN];
                ctrl_a[SAC_A_PRESC_LSB +: 3] <= hwdata[SAC_A_PRESC_LSB +: 3];
            end
            if (done_pulse) begin
                ctrl_a[SAC_A_DONE] <= 1'b1;
            end else if (wr_a && hwdata[SAC_A_DONE]) begin
                ctrl_a[SAC_A_DONE] <= 1'b0;
            end
            // Start bit reads one from request until completion
            ctrl_a[SAC_A_START] <= converter_enable
                                   && (sw_start || auto_start || pending || busy)
                                   && !(done_pulse && !self_restart);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trigger_source_select <= SAC_RST_CTRL_B[2:0];
            input_select_register <= SAC_RST_INSEL;
        end else begin
            if (wr_b) begin
                trigger_source_select <= hwdata[2:0];
            end
            if (wr_isel) begin
                input_select_register <= hwdata[7:0];
            end
        end
    end

    // Result store with two-byte read lock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result        <= '0;
            result_locked <= 1'b0;
            first_done    <= 1'b0;
        end else begin
            if (done_pulse && !result_locked) begin
                result <= sar;
            end
            if (rd_high) begin
                result_locked <= 1'b0;
            end else if (rd_low) begin
                result_locked <= 1'b1;
            end
            if (!converter_enable) begin
                first_done <= 1'b0;
            end else if (done_pulse) begin
                first_done <= 1'b1;
            end
        end
    end

    // Channel and gain decode
    wire [4:0] channel_gain_select = input_select_register[SAC_I_CHAN_LSB +: 5];
    wire [1:0] reference_select    = input_select_register[SAC_I_REF_LSB +: 2];
    sac_afe_t  afe_live;
    always_comb begin
        afe_live             = '0;
        afe_live.active      = converter_enable;
        afe_live.reference   = reference_select;
        afe_live.ref_to_pin  = reference_select == SAC_REF_SUPPLY
                               || reference_select == SAC_REF_INT256;
        case (channel_gain_select[4:3])
            2'b00: begin
                afe_live.source   = SAC_SRC_PIN;
                afe_live.pos_chan = channel_gain_select[2:0];
            end
            2'b01: begin
                afe_live.source      = SAC_SRC_DIFF;
                afe_live.pos_chan    = {2'b00, channel_gain_select[0]} | {channel_gain_select[2], 2'b00};
                afe_live.neg_chan    = {channel_gain_select[2], 1'b0, 1'b0};
                afe_live.gain        = channel_gain_select[1] ? 2'd2 : 2'd1;
            end
            2'b10: begin
                afe_live.source   = SAC_SRC_DIFF;
                afe_live.pos_chan = channel_gain_select[2:0];
                afe_live.neg_chan = 3'd1;
            end
            default: begin
                afe_live.source   = (channel_gain_select == 5'h1E) ? SAC_SRC_BANDGAP
                                  : (channel_gain_select == 5'h1F) ? SAC_SRC_GND
                                  : SAC_SRC_DIFF;
                afe_live.pos_chan = channel_gain_select[2:0];
                afe_live.neg_chan = 3'd2;
            end
        endcase
        afe_live.gain_bypass = afe_live.source != SAC_SRC_DIFF;
        if (!converter_enable) begin
            afe_live.source = SAC_SRC_GND;
        end
    end

    // Selection frozen while a conversion runs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            afe_lock <= '0;
            afe      <= '0;
        end else begin
            if (state == SAC_IDLE) begin
                afe_lock <= afe_live;
            end
            afe <= (state == SAC_IDLE || !converter_enable) ? afe_live : afe_lock;
        end
    end

    // Read mux and bus answer
    wire [7:0] rd_sel = (dp_addr == SAC_OFF_CTRL_A)   ? ctrl_a
                      : (dp_addr == SAC_OFF_CTRL_B)   ? {5'h00, trigger_source_select}
                      : (dp_addr == SAC_OFF_INSEL)    ? input_select_register
                      : (dp_addr == SAC_OFF_RES_LOW)  ? result_low_byte
                      : (dp_addr == SAC_OFF_RES_HIGH) ? result_high_byte
                      : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hreadyout      <= 1'b1;
            hresp          <= 1'b0;
            conversion_irq <= 1'b0;
        end else begin
            hreadyout      <= 1'b1;
            hresp          <= 1'b0;
            conversion_irq <= conversion_done_flag && conversion_irq_enable;
        end
    end

    assign hrdata = {24'h00_0000, rd_sel};

endmodule : sac_top

// ==== tb/sac_top_assertions.sv ====
`timescale 1ns/10ps
module sac_top_assertions
    import sac_pkg::*;
#(
    parameter int RES_BITS = SAC_RES_BITS
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              hsel,
    input wire logic [7:0]        haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire sac_pkg::sac_afe_t afe,
    input wire logic              conversion_irq
);
    logic       dp_vld;
    logic       dp_wr;
    logic [7:0] dp_adr;
    logic       lk;
    logic [7:0] lk_lo;
    wire        rd_dp  = dp_vld & ~dp_wr;
    wire        low_rd = rd_dp & (dp_adr == SAC_OFF_RES_LOW);
    wire        hi_rd  = rd_dp & (dp_adr == SAC_OFF_RES_HIGH);

    // Shadow of the transfer now in its data phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dp_vld <= 1'b0;
        end else if (hready) begin
            dp_vld <= hsel & htrans[1];
            dp_wr  <= hwrite;
            dp_adr <= haddr;
        end
    end

    // Low byte seen at lock time; only meaningful while lk is set
    always_ff @(posedge clk) begin
        if (!rst_n || hi_rd) begin
            lk <= 1'b0;
        end else if (low_rd && !lk) begin
            lk    <= 1'b1;
            lk_lo <= hrdata[7:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence ctl_wr_s;
        dp_vld && dp_wr && dp_adr == SAC_OFF_CTRL_A;
    endsequence
    sequence locked_low_s;
        low_rd && lk;
    endsequence

    enable_gate_a: assert property (ctl_wr_s ##0 !hwdata[SAC_A_ENABLE] |-> ##[1:2] !afe.active)
        else $error("front end active after disable");
    irq_mask_a: assert property (ctl_wr_s ##0 !hwdata[SAC_A_IRQ_EN] |-> ##[1:2] !conversion_irq)
        else $error("irq high while masked");
    single_bypass_a: assert property (afe.active && afe.source != SAC_SRC_DIFF |-> afe.gain_bypass)
        else $error("gain stage used on single input");
    diff_gain_a: assert property (afe.active && afe.source == SAC_SRC_DIFF |-> !afe.gain_bypass)
        else $error("gain stage bypassed on pair");
    int_ref_a: assert property (afe.active && afe.reference == SAC_REF_INT256 |-> afe.ref_to_pin)
        else $error("internal reference not on pin");
    lock_hold_a: assert property (locked_low_s |-> hrdata[7:0] == lk_lo)
        else $error("low byte changed while locked");
    byte_read_a: assert property (rd_dp |-> hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    unmapped_read_a: assert property (rd_dp && dp_adr > SAC_OFF_RES_HIGH |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    zero_wait_a: assert property (hreadyout && !hresp)
        else $error("wait state or error response");
endmodule : sac_top_assertions

bind sac_top sac_top_assertions #(
    .RES_BITS(RES_BITS)
) sac_top_assertions_inst (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .afe(afe), .conversion_irq(conversion_irq)
);

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import sac_pkg::*;
    logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, comparator_high, conversion_irq, sh;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [7:1]  trigger_sources;
    logic [9:0]  dac_code, target;
    sac_afe_t    afe;
    sac_src_t    src;
    logic [15:0] res_q[$];
    logic        left, lock, seen;
    logic [7:0]  offs[4] = '{SAC_OFF_CTRL_A, SAC_OFF_CTRL_B, SAC_OFF_INSEL, 8'h14};
    int          bad_count, n_compared, cyc, len, t0;

    sac_top #(.RES_BITS(SAC_RES_BITS)) sac_top_inst (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .trigger_sources(trigger_sources), .comparator_high(comparator_high),
        .dac_code(dac_code), .sample_hold(sh), .afe(afe), .conversion_irq(conversion_irq)
    );

    // Clock and a running cycle count
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // Analog stand-in: keep the trial bit while the input is at or above it
    always @(posedge clk) comparator_high <= (dac_code <= target);

    task automatic summarize;
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    task automatic hang;
        bad_count++;
        summarize();
    endtask : hang

    // Single word transfer; read data taken as the data phase closes
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int   n;
        logic rdy;
        n = 0;
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) hang();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge clk);
            n++;
            rd  = hrdata;
            rdy = hreadyout;
        end while (rdy !== 1'b1 && n < 100);
        if (n >= 100) hang();
    endtask : bus

    // Poll the done flag; len is clocks since t0
    task automatic wait_done;
        int k;
        k = 0;
        do begin
            bus(1'b0, SAC_OFF_CTRL_A, 32'h0);
            k++;
        end while (rd[SAC_A_DONE] !== 1'b1 && k < 100);
        if (k >= 100) hang();
        len = cyc - t0;
    endtask : wait_done

    // Software start; a result lands in the model only when bytes are free
    task automatic conv(input logic [7:0] ctl);
        t0 = cyc;
        bus(1'b1, SAC_OFF_CTRL_A, {24'h0, ctl});
        bus(1'b0, SAC_OFF_CTRL_A, 32'h0);
        `CHK("start bit", 1'b1, rd[SAC_A_START])
        wait_done();
        `CHK("start cleared", 1'b0, rd[SAC_A_START])
        `CHK("hold released", 1'b0, sh)
        if (!lock) res_q.push_back(left ? {target, 6'h0} : {6'h0, target});
    endtask : conv

    task automatic rdres;
        logic [15:0] e;
        e = res_q[$];
        bus(1'b0, SAC_OFF_RES_LOW, 32'h0);
        `CHK("low byte", {24'h0, e[7:0]}, rd)
        bus(1'b0, SAC_OFF_RES_HIGH, 32'h0);
        `CHK("high byte", {24'h0, e[15:8]}, rd)
        lock = 1'b0;
    endtask : rdres

    // Clear done, then watch that nothing starts by itself
    task automatic idle_chk;
        bus(1'b1, SAC_OFF_CTRL_A, 32'hB9);
        seen = 1'b0;
        repeat (40) begin
            bus(1'b0, SAC_OFF_CTRL_A, 32'h0);
            seen = seen | rd[SAC_A_DONE];
        end
    endtask : idle_chk

    initial begin
        {rst_n, hsel, hwrite, haddr, htrans, hwdata, target, left, lock} = '0;
        {trigger_sources, comparator_high} = '0;
        hsize = 3'b010;
        target = 10'($urandom(38));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values; the unmapped word ignores writes
        bus(1'b1, 8'h14, 32'hFFFF_FFFF);
        foreach (offs[i]) begin
            bus(1'b0, offs[i], 32'h0);
            `CHK("reset value", 32'h0, rd)
        end
        // Every channel code except 24 to 29 with the converter on and internal reference
        bus(1'b1, SAC_OFF_CTRL_A, 32'h81);
        for (int c = 0; c < 32; c++) begin
            if (c < 24 || c > 29) begin
                bus(1'b1, SAC_OFF_INSEL, 32'hC0 | c);
                bus(1'b0, SAC_OFF_INSEL, 32'h0);
                src = c < 8 ? SAC_SRC_PIN : c < 24 ? SAC_SRC_DIFF :
                      c == 30 ? SAC_SRC_BANDGAP : SAC_SRC_GND;
                `CHK("source", src, afe.source)
                if (c < 8) `CHK("channel", 3'(c), afe.pos_chan)
            end
        end
        // First conversion after enable is long, the next one short
        bus(1'b1, SAC_OFF_INSEL, 32'h0);
        target = 10'($urandom);
        conv(8'hD9);
        `CHK("first length", 1'b1, len >= 96)
        rdres();
        target = 10'($urandom);
        conv(8'hD9);
        `CHK("normal length", 1'b1, len >= 48 && len <= 76)
        rdres();
        // Left alignment, then a lone low read locks both bytes
        bus(1'b1, SAC_OFF_INSEL, 32'h20);
        left = 1'b1;
        target = 10'($urandom);
        conv(8'hD9);
        rdres();
        bus(1'b0, SAC_OFF_RES_LOW, 32'h0);
        lock = 1'b1;
        target = ~target;
        conv(8'hD9);
        rdres();
        target = 10'($urandom);
        conv(8'hD9);
        rdres();
        `CHK("irq", 1'b1, conversion_irq)
        bus(1'b1, SAC_OFF_CTRL_A, 32'h90);
        bus(1'b0, SAC_OFF_CTRL_A, 32'h0);
        `CHK("done cleared", 1'b0, rd[SAC_A_DONE])
        `CHK("irq off", 1'b0, conversion_irq)
        // Channel written mid-conversion waits for the end
        left = 1'b0;
        bus(1'b1, SAC_OFF_INSEL, 32'h0);
        target = 10'($urandom);
        t0 = cyc;
        bus(1'b1, SAC_OFF_CTRL_A, 32'hD9);
        bus(1'b0, SAC_OFF_CTRL_A, 32'h0);
        bus(1'b1, SAC_OFF_INSEL, 32'h05);
        repeat (3) @(posedge clk);
        `CHK("old channel", 3'h0, afe.pos_chan)
        wait_done();
        res_q.push_back({6'h0, target});
        `CHK("new channel", 3'h5, afe.pos_chan)
        rdres();
        // Trigger edge starts once; held level or mid-run pulse start nothing
        bus(1'b1, SAC_OFF_CTRL_B, 32'h3);
        bus(1'b1, SAC_OFF_CTRL_A, 32'hB9);
        target = 10'($urandom);
        trigger_sources[3] <= 1'b1;
        wait_done();
        res_q.push_back({6'h0, target});
        rdres();
        idle_chk();
        `CHK("held trigger", 1'b0, seen)
        trigger_sources[3] <= 1'b0;
        @(posedge clk);
        trigger_sources[3] <= 1'b1;
        repeat (20) @(posedge clk);
        trigger_sources[3] <= 1'b0;
        @(posedge clk);
        trigger_sources[3] <= 1'b1;
        @(posedge clk);
        trigger_sources[3] <= 1'b0;
        wait_done();
        idle_chk();
        `CHK("mid-run edge", 1'b0, seen)
        target = 10'($urandom);
        conv(8'hF9);
        rdres();
        // Own done flag as source: one software start, then it runs on
        bus(1'b1, SAC_OFF_CTRL_B, 32'h0);
        t0 = cyc;
        bus(1'b1, SAC_OFF_CTRL_A, 32'hF9);
        wait_done();
        target = 10'($urandom);
        repeat (40) bus(1'b0, SAC_OFF_CTRL_A, 32'h0);
        `CHK("free running", 1'b1, rd[SAC_A_START])
        res_q.push_back({6'h0, target});
        rdres();
        bus(1'b1, SAC_OFF_CTRL_A, 32'h0);
        repeat (3) @(posedge clk);
        `CHK("disabled", 1'b0, afe.active)
        `CHK("disabled source", SAC_SRC_GND, afe.source)
        summarize();
    end
endmodule : tb_top
